// >>> core/esd_cfg.svh
`ifndef ESD_CFG_SVH
`define ESD_CFG_SVH

// Register offsets
`define ESD_OFS_LDO_B_DELAY 8'h0F
`define ESD_OFS_AUX_A_DELAY 8'h10
`define ESD_OFS_AUX_B_DELAY 8'h11
`define ESD_OFS_AUX_CTRL 8'h12
`define ESD_OFS_DEV_CFG 8'h13

// Register reset values
`define ESD_RST_LDO_B_DELAY 8'h26
`define ESD_RST_AUX_A_DELAY 8'h0A
`define ESD_RST_AUX_B_DELAY 8'h31
`define ESD_RST_AUX_CTRL 8'h77
`define ESD_RST_DEV_CFG 8'h46

// Delay register fields
`define ESD_FLD_OFF_HI 7
`define ESD_FLD_OFF_LO 4
`define ESD_FLD_ON_HI 3
`define ESD_FLD_ON_LO 0

// Output control fields
`define ESD_BIT_B_DRIVE_TYPE 6
`define ESD_BIT_B_PIN_GATING 5
`define ESD_BIT_B_LEVEL 4
`define ESD_BIT_A_DRIVE_TYPE 2
`define ESD_BIT_A_PIN_GATING 1
`define ESD_BIT_A_LEVEL 0
`define ESD_AUX_CTRL_RW_MASK 8'h77

// Configuration fields
`define ESD_BIT_ON_RANGE 6
`define ESD_BIT_OFF_RANGE 5
`define ESD_BIT_SHARED_FN 4
`define ESD_BIT_SHARED_PD 3
`define ESD_BIT_ENABLE_PD 2
`define ESD_BIT_THERMAL_SEL 1
`define ESD_BIT_SPREAD 0

// Timing: half-millisecond step at a 20 ns clock
`define ESD_STEP_TIME_NS 500000
`define ESD_CLK_PERIOD_NS 20
`define ESD_STEP_CYCLES (`ESD_STEP_TIME_NS / `ESD_CLK_PERIOD_NS)

`endif

// >>> core/esd_pkg.sv
package esd_pkg;

	// Pending state of one delay channel
	typedef enum logic [1:0] {
		ESD_IDLE = 2'b00,
		ESD_WAIT_ON = 2'b01,
		ESD_WAIT_OFF = 2'b10
	} esd_wait_e;

	// Delay in half-millisecond ticks
	typedef logic [4:0] esd_ticks_t;

endpackage

// >>> core/esd_delay_chan.sv
`timescale 1ns/100ps

// One delayed copy of the enable pin
module esd_delay_chan (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	// Enable edges and time base
	input wire logic en_rise,
	input wire logic en_fall,
	input wire logic tick,
	// Delays in ticks
	input wire esd_pkg::esd_ticks_t on_ticks,
	input wire esd_pkg::esd_ticks_t off_ticks,
	// Delayed enable state
	output logic seq_on
);

	esd_pkg::esd_wait_e wait_st;
	esd_pkg::esd_ticks_t cnt;

	// Edge restarts the count; an opposite edge drops the pending one
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wait_st <= esd_pkg::ESD_IDLE;
			cnt <= 5'h00;
			seq_on <= 1'h0;
		end
		else if (clk_en)
		begin
			if (en_rise)
			begin
				// RULE_19 restart on edge
				cnt <= on_ticks;
				if (on_ticks == 5'h00)
				begin
					seq_on <= 1'h1;
					wait_st <= esd_pkg::ESD_IDLE;
				end
				else
				begin
					wait_st <= esd_pkg::ESD_WAIT_ON;
				end
			end
			else if (en_fall)
			begin
				cnt <= off_ticks;
				if (off_ticks == 5'h00)
				begin
					seq_on <= 1'h0;
					wait_st <= esd_pkg::ESD_IDLE;
				end
				else
				begin
					wait_st <= esd_pkg::ESD_WAIT_OFF;
				end
			end
			else if (tick)
			begin
				case (wait_st)
					esd_pkg::ESD_WAIT_ON,
					esd_pkg::ESD_WAIT_OFF:
					begin
						if (cnt == 5'h01)
						begin
							seq_on <= (wait_st == esd_pkg::ESD_WAIT_ON);
							wait_st <= esd_pkg::ESD_IDLE;
						end
						cnt <= cnt - 5'h01;
					end
					default:
					begin
						wait_st <= esd_pkg::ESD_IDLE;
					end
				endcase
			end
		end
	end

	// Zero delay switches on at once
	AST_ZERO_ON: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_02
		clk_en && en_rise && (on_ticks == 5'h00) |=> seq_on)
		else $error("zero startup delay did not switch on");

	// Opposite edge abandons a pending turn-on
	AST_ABANDON: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_19
		clk_en && en_fall |=> (wait_st != esd_pkg::ESD_WAIT_ON))
		else $error("pending turn-on survived a falling edge");

	// Output held on while a shutdown delay runs
	AST_HOLD_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_01
		clk_en && en_fall && (off_ticks != 5'h00) && seq_on |=> seq_on)
		else $error("output dropped before shutdown delay");

	// Last tick of a pending turn-on switches on
	AST_LAST_TICK: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_19
		clk_en && tick && !en_rise && !en_fall && (wait_st == esd_pkg::ESD_WAIT_ON)
		&& (cnt == 5'h01) |=> seq_on && (wait_st == esd_pkg::ESD_IDLE))
		else $error("turn-on delay did not complete");

endmodule

// >>> core/esd_seq_top.sv
`timescale 1ns/100ps
`include "esd_cfg.svh"

// Contract
// RULE_01 - Regulator stays on for shutdown code steps
// RULE_02 - Regulator turns on after startup code steps
// RULE_03 - Output A falls after its shutdown delay
// RULE_04 - Output A rises after its startup delay
// RULE_05 - Output B falls after its shutdown delay
// RULE_06 - Output B rises after its startup delay
// RULE_07 - Startup range bit picks half or full ms
// RULE_08 - Shutdown range bit picks half or full ms
// RULE_09 - Output B push-pull or open-drain select
// RULE_10 - Output B follows level, optionally gated
// RULE_11 - Output B level bit sets pin level
// RULE_12 - Output A push-pull or open-drain select
// RULE_13 - Output A follows level, optionally gated
// RULE_14 - Output A level bit sets pin level
// RULE_15 - Shared pin is output B or clock
// RULE_16 - Pull-down selects for shared and enable pins
// RULE_17 - Thermal warning threshold select bit
// RULE_18 - Spread-spectrum enable bit
// RULE_19 - Delays restart on edge, opposite edge aborts
// RULE_20 - Gated output is level AND delayed enable
module esd_seq_top #(
	parameter int STEP_CYCLES = `ESD_STEP_CYCLES
) (
	// Clock, reset, clock enable
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	// Enable pin
	input wire logic enable_pin,
	// Register port from the serial interface
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Sequenced regulator enable
	output logic linear_reg_b_on,
	// General-purpose output pins
	output logic aux_out_a,
	output logic aux_out_a_oe_b,
	output logic aux_out_b,
	output logic aux_out_b_oe_b,
	// Configuration levels
	output logic shared_pin_function,
	output logic shared_pin_pulldown,
	output logic enable_pin_pulldown,
	output logic thermal_warn_threshold,
	output logic spread_spectrum_on
);

	localparam int PRE_W = $clog2(STEP_CYCLES);

	// Parameter check
	generate
		if (STEP_CYCLES < 3)
		begin : g_bad_step
			$error("STEP_CYCLES must be at least 3");
		end
	endgenerate

	logic [7:0] linear_reg_b_sequence_delay;
	logic [7:0] aux_out_a_sequence_delay;
	logic [7:0] aux_out_b_sequence_delay;
	logic [7:0] aux_output_control;
	logic [7:0] device_configuration;
	logic en_s1;
	logic en_s2;
	logic en_d;
	logic en_rise;
	logic en_fall;
	logic [PRE_W-1:0] pre_cnt;
	logic tick;
	logic [3:0] on_code [3];
	logic [3:0] off_code [3];
	logic [2:0] seq_on;
	logic next_a;
	logic next_b;

	// Register writes from the serial interface
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			linear_reg_b_sequence_delay <= `ESD_RST_LDO_B_DELAY;
			aux_out_a_sequence_delay <= `ESD_RST_AUX_A_DELAY;
			aux_out_b_sequence_delay <= `ESD_RST_AUX_B_DELAY;
			aux_output_control <= `ESD_RST_AUX_CTRL;
			device_configuration <= `ESD_RST_DEV_CFG;
		end
		else if (clk_en && reg_wr)
		begin
			case (reg_addr)
				`ESD_OFS_LDO_B_DELAY: linear_reg_b_sequence_delay <= reg_wdata;
				`ESD_OFS_AUX_A_DELAY: aux_out_a_sequence_delay <= reg_wdata;
				`ESD_OFS_AUX_B_DELAY: aux_out_b_sequence_delay <= reg_wdata;
				`ESD_OFS_AUX_CTRL: aux_output_control <= reg_wdata & `ESD_AUX_CTRL_RW_MASK;
				`ESD_OFS_DEV_CFG: device_configuration <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read data, unmapped reads return zero
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reg_rdata <= 8'h00;
		end
		else if (clk_en && reg_rd)
		begin
			case (reg_addr)
				`ESD_OFS_LDO_B_DELAY: reg_rdata <= linear_reg_b_sequence_delay;
				`ESD_OFS_AUX_A_DELAY: reg_rdata <= aux_out_a_sequence_delay;
				`ESD_OFS_AUX_B_DELAY: reg_rdata <= aux_out_b_sequence_delay;
				`ESD_OFS_AUX_CTRL: reg_rdata <= aux_output_control;
				`ESD_OFS_DEV_CFG: reg_rdata <= device_configuration;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Enable pin synchroniser and edge detect
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			en_s1 <= 1'h0;
			en_s2 <= 1'h0;
			en_d <= 1'h0;
		end
		else if (clk_en)
		begin
			en_s1 <= enable_pin;
			en_s2 <= en_s1;
			en_d <= en_s2;
		end
	end

	assign en_rise = en_s2 && !en_d;
	assign en_fall = !en_s2 && en_d;

	// Half-millisecond time base, restarted by every enable edge
	// RULE_19 common time base
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pre_cnt <= '0;
		end
		else if (clk_en)
		begin
			if (en_rise || en_fall || tick)
			begin
				pre_cnt <= '0;
			end
			else
			begin
				pre_cnt <= pre_cnt + PRE_W'(1);
			end
		end
	end

	assign tick = (pre_cnt == PRE_W'(STEP_CYCLES - 1));

	// Delay codes per channel: regulator, output A, output B
	// RULE_01 regulator codes
	// RULE_03 output A codes
	// RULE_05 output B codes
	// RULE_04 A startup code
	// RULE_06 B startup code
	always_comb
	begin
		on_code[0] = linear_reg_b_sequence_delay[`ESD_FLD_ON_HI:`ESD_FLD_ON_LO];
		off_code[0] = linear_reg_b_sequence_delay[`ESD_FLD_OFF_HI:`ESD_FLD_OFF_LO];
		on_code[1] = aux_out_a_sequence_delay[`ESD_FLD_ON_HI:`ESD_FLD_ON_LO];
		off_code[1] = aux_out_a_sequence_delay[`ESD_FLD_OFF_HI:`ESD_FLD_OFF_LO];
		on_code[2] = aux_out_b_sequence_delay[`ESD_FLD_ON_HI:`ESD_FLD_ON_LO];
		off_code[2] = aux_out_b_sequence_delay[`ESD_FLD_OFF_HI:`ESD_FLD_OFF_LO];
	end

	// Delay channels
	generate
		for (genvar i = 0; i < 3; i++)
		begin : g_chan
			esd_pkg::esd_ticks_t on_t;
			esd_pkg::esd_ticks_t off_t;
			// RULE_07 startup step scaling
			assign on_t = device_configuration[`ESD_BIT_ON_RANGE] ?
				{on_code[i], 1'h0} : {1'h0, on_code[i]};
			// RULE_08 shutdown step scaling
			assign off_t = device_configuration[`ESD_BIT_OFF_RANGE] ?
				{off_code[i], 1'h0} : {1'h0, off_code[i]};
			esd_delay_chan u_chan (
				.ref_clk(ref_clk),
				.rst_b(rst_b),
				.clk_en(clk_en),
				.en_rise(en_rise),
				.en_fall(en_fall),
				.tick(tick),
				.on_ticks(on_t),
				.off_ticks(off_t),
				.seq_on(seq_on[i])
			);
		end
	endgenerate

	// RULE_02 regulator follows its delayed enable
	assign linear_reg_b_on = seq_on[0];

	// Pin levels: level bit alone, or ANDed with the delayed enable
	always_comb
	begin
		// RULE_13 output A gating
		// RULE_20 level AND delayed enable
		next_a = aux_output_control[`ESD_BIT_A_LEVEL] &&
			(!aux_output_control[`ESD_BIT_A_PIN_GATING] || seq_on[1]);
		// RULE_10 output B gating
		next_b = aux_output_control[`ESD_BIT_B_LEVEL] &&
			(!aux_output_control[`ESD_BIT_B_PIN_GATING] || seq_on[2]);
	end

	// Pin drivers; open-drain releases the pin when high
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			aux_out_a <= 1'h0;
			aux_out_a_oe_b <= 1'h1;
			aux_out_b <= 1'h0;
			aux_out_b_oe_b <= 1'h1;
		end
		else if (clk_en)
		begin
			// RULE_14 output A level
			aux_out_a <= next_a;
			// RULE_12 output A drive type
			aux_out_a_oe_b <= aux_output_control[`ESD_BIT_A_DRIVE_TYPE] && next_a;
			// RULE_11 output B level
			aux_out_b <= next_b;
			// RULE_09 output B drive type
			// RULE_15 clock function releases the pin
			aux_out_b_oe_b <= device_configuration[`ESD_BIT_SHARED_FN] ||
				(aux_output_control[`ESD_BIT_B_DRIVE_TYPE] && next_b);
		end
	end

	// Configuration levels
	// RULE_15 shared pin function
	assign shared_pin_function = device_configuration[`ESD_BIT_SHARED_FN];
	// RULE_16 pull-down selects
	assign shared_pin_pulldown = device_configuration[`ESD_BIT_SHARED_PD];
	assign enable_pin_pulldown = device_configuration[`ESD_BIT_ENABLE_PD];
	// RULE_17 thermal threshold
	assign thermal_warn_threshold = device_configuration[`ESD_BIT_THERMAL_SEL];
	// RULE_18 spread spectrum
	assign spread_spectrum_on = device_configuration[`ESD_BIT_SPREAD];

	// Ungated output A copies its level bit
	AST_A_DIRECT: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_13
		clk_en && !aux_output_control[`ESD_BIT_A_PIN_GATING]
		|=> aux_out_a == $past(aux_output_control[`ESD_BIT_A_LEVEL]))
		else $error("output A does not follow its level bit");

	// Gated output A is level AND delayed enable
	AST_A_GATED: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_20
		clk_en && aux_output_control[`ESD_BIT_A_PIN_GATING]
		|=> aux_out_a == ($past(aux_output_control[`ESD_BIT_A_LEVEL]) && $past(seq_on[1])))
		else $error("gated output A wrong");

	// Open-drain output B never drives high
	AST_B_OPEN_DRAIN: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_09
		clk_en && aux_output_control[`ESD_BIT_B_DRIVE_TYPE] |=> !(aux_out_b && !aux_out_b_oe_b))
		else $error("open-drain output B drove high");

	// Clock function leaves the shared pin undriven
	AST_B_CLOCK_IN: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_15
		clk_en && device_configuration[`ESD_BIT_SHARED_FN] |=> aux_out_b_oe_b)
		else $error("shared pin driven while in clock function");

	// Gated output B drops with its delayed enable
	AST_B_GATED: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_10
		clk_en && aux_output_control[`ESD_BIT_B_PIN_GATING] && !seq_on[2] |=> !aux_out_b)
		else $error("gated output B high without delayed enable");

	// Time base restarts on an enable edge
	AST_TICK_SPACING: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_19
		clk_en && (en_rise || en_fall) |=> (pre_cnt == '0) ##1 !tick)
		else $error("time base not restarted by enable edge");

	// Push-pull output A always drives its pin
	AST_A_PUSH_PULL: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_12
		clk_en && !aux_output_control[`ESD_BIT_A_DRIVE_TYPE] |=> !aux_out_a_oe_b)
		else $error("push-pull output A released its pin");

	// Ungated output B copies its level bit
	AST_B_DIRECT: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_11
		clk_en && !aux_output_control[`ESD_BIT_B_PIN_GATING]
		|=> aux_out_b == $past(aux_output_control[`ESD_BIT_B_LEVEL]))
		else $error("output B does not follow its level bit");

	// Clearing the level bit drops output A without waiting for a delay
	AST_LEVEL_NO_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_20
		clk_en && !aux_output_control[`ESD_BIT_A_LEVEL] |=> !aux_out_a)
		else $error("output A high with its level bit clear");

endmodule

// >>> verif/esd_host_model.sv
`timescale 1ns/100ps

// Host side: drives the enable pin and the register port
module esd_host_model (
	// Clock
	input wire logic ref_clk,
	// Enable pin drive
	output logic enable_pin,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	// Idle levels from time zero
	initial
	begin
		enable_pin = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// One byte write, strobe high for a single edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// One byte read, data taken once the strobe edge has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Enable pin changes just after an edge
	task automatic set_en(input logic v);
		@(posedge ref_clk);
		enable_pin <= v;
	endtask
endmodule

// >>> verif/tb_esd_seq_top.sv
`timescale 1ns/100ps

// Register and sequencing checks for the enable delay block
module tb_esd_seq_top;
	localparam int S = 4;
	logic ref_clk;
	logic rst_b;
	logic enable_pin;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic linear_reg_b_on;
	logic aux_out_a;
	logic aux_out_a_oe_b;
	logic aux_out_b;
	logic aux_out_b_oe_b;
	logic [4:0] cfg_out;
	logic [7:0] v;
	int n_mismatch = 0;
	int total_checks = 0;
	int t_reg;
	int t_a;
	int t_b;
	logic [7:0] rst_adr [6] = '{8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
	logic [7:0] rst_val [6] = '{8'h26, 8'h0A, 8'h31, 8'h77, 8'h46, 8'h00};
	logic [7:0] ctl_tab [5] = '{8'h55, 8'h11, 8'h00, 8'h33, 8'h45};
	logic [3:0] pin_tab [5] = '{4'b1111, 4'b1010, 4'b0000, 4'b0000, 4'b1100};

	// Design under test with a short step
	esd_seq_top #(.STEP_CYCLES(S)) u_dut (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clk_en(1'b1),
		.enable_pin(enable_pin),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.linear_reg_b_on(linear_reg_b_on),
		.aux_out_a(aux_out_a),
		.aux_out_a_oe_b(aux_out_a_oe_b),
		.aux_out_b(aux_out_b),
		.aux_out_b_oe_b(aux_out_b_oe_b),
		.shared_pin_function(cfg_out[4]),
		.shared_pin_pulldown(cfg_out[3]),
		.enable_pin_pulldown(cfg_out[2]),
		.thermal_warn_threshold(cfg_out[1]),
		.spread_spectrum_on(cfg_out[0])
	);

	// Host drives the pin and the register port
	esd_host_model u_host (
		.ref_clk(ref_clk),
		.enable_pin(enable_pin),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata)
	);

	// Clock at 20 ns
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Expected cycles from pin change to output change; extra is sync and flop latency
	function automatic int dly(input int code, input logic rng, input int extra);
		return code * (rng ? 2 : 1) * S + extra;
	endfunction

	// Moves the pin, then records when each output first reaches the new level
	task automatic meas(input logic lvl, input int lim);
		t_reg = -1;
		t_a = -1;
		t_b = -1;
		u_host.set_en(lvl);
		for (int n = 1; n <= lim; n++)
		begin
			@(posedge ref_clk);
			#1;
			if (t_reg < 0 && linear_reg_b_on === lvl) t_reg = n;
			if (t_a < 0 && aux_out_a === lvl) t_a = n;
			if (t_b < 0 && aux_out_b === lvl) t_b = n;
		end
	endtask

	// Closing report
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
		begin
			$display("STATUS OK");
		end
		else
		begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Cuts a hang short
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		print_verdict();
	end

	// Test sequence
	initial
	begin
		rst_b = 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			u_host.rd(rst_adr[i], v);
			chk(v, rst_val[i]);
		end
		chk({3'b000, cfg_out}, 8'h06);
		u_host.wr(8'h12, 8'hFF);
		u_host.rd(8'h12, v);
		chk(v, 8'h77);
		u_host.wr(8'h12, 8'h77);
		$display("test reset values done");
		meas(1'b1, 100);
		chk(8'(t_reg), 8'(dly(6, 1, 3)));
		chk(8'(t_a), 8'(dly(10, 1, 4)));
		chk(8'(t_b), 8'(dly(1, 1, 4)));
		meas(1'b0, 40);
		chk(8'(t_reg), 8'(dly(2, 0, 3)));
		chk(8'(t_a), 8'(dly(0, 0, 4)));
		chk(8'(t_b), 8'(dly(3, 0, 4)));
		$display("test default sequence done");
		u_host.wr(8'h13, 8'h26);
		u_host.wr(8'h0F, 8'h0F);
		u_host.wr(8'h10, 8'hF0);
		u_host.wr(8'h11, 8'h5F);
		u_host.rd(8'h11, v);
		chk(v, 8'h5F);
		u_host.rd(8'h13, v);
		chk(v, 8'h26);
		chk({3'b000, cfg_out}, 8'h06);
		meas(1'b1, 80);
		chk(8'(t_reg), 8'(dly(15, 0, 3)));
		chk(8'(t_a), 8'(dly(0, 0, 4)));
		chk(8'(t_b), 8'(dly(15, 0, 4)));
		meas(1'b0, 140);
		chk(8'(t_reg), 8'(dly(0, 1, 3)));
		chk(8'(t_a), 8'(dly(15, 1, 4)));
		chk(8'(t_b), 8'(dly(5, 1, 4)));
		$display("test range and boundary done");
		meas(1'b1, 20);
		chk(8'(t_reg), 8'hFF);
		chk(8'(t_a), 8'(dly(0, 0, 4)));
		chk(8'(t_b), 8'hFF);
		meas(1'b0, 140);
		chk(8'(t_a), 8'(dly(15, 1, 4)));
		chk({7'h00, linear_reg_b_on | aux_out_b}, 8'h00);
		$display("test abandoned delay done");
		for (int i = 0; i < 5; i++)
		begin
			u_host.wr(8'h12, ctl_tab[i]);
			repeat (3) @(posedge ref_clk);
			#1;
			v = {4'h0, aux_out_a, aux_out_a_oe_b, aux_out_b, aux_out_b_oe_b};
			chk(v, {4'h0, pin_tab[i]});
		end
		u_host.wr(8'h12, 8'h11);
		u_host.wr(8'h13, 8'h5F);
		repeat (3) @(posedge ref_clk);
		#1;
		chk({7'h00, aux_out_b_oe_b}, 8'h01);
		chk({3'b000, cfg_out}, 8'h1F);
		u_host.wr(8'h13, 8'h40);
		repeat (2) @(posedge ref_clk);
		#1;
		chk({3'b000, cfg_out}, 8'h00);
		$display("test output control done");
		print_verdict();
	end
endmodule
